// ==== pkg/cl_drive_pkg.sv ====
// Shared constants and types for the closed-loop drive configuration block.
// Assumes a single system clock domain and an 8-bit register port.
package cl_drive_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] ADDR_FULLSCALE = 8'h1F;
  localparam logic [7:0] ADDR_OD_LIMIT  = 8'h20;
  localparam logic [7:0] ADDR_COMP      = 8'h21;
  localparam logic [7:0] ADDR_FB_GAIN   = 8'h22;
  localparam logic [7:0] ADDR_FB_CTRL   = 8'h23;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] RST_FULLSCALE = 8'h3F;
  localparam logic [7:0] RST_OD_LIMIT  = 8'hFF;
  localparam logic [7:0] RST_COMP      = 8'h0D;
  localparam logic [7:0] RST_FB_GAIN   = 8'h6D;
  localparam logic [7:0] RST_FB_CTRL   = 8'h36;

  // ********************************
  // Feedback control field layout
  // ********************************
  localparam int NG_BIT        = 7;
  localparam int BRAKE_MSB     = 6;
  localparam int BRAKE_LSB     = 4;
  localparam int LOOP_MSB      = 3;
  localparam int LOOP_LSB      = 2;
  localparam int AMP_MSB       = 1;
  localparam int AMP_LSB       = 0;
  localparam logic [2:0] BRAKE_OFF_CODE = 3'h7;

  // ********************************
  // Noise gate levels, percent of supply
  // ********************************
  localparam logic [15:0] NG_PCT_LOW  = 16'h0004;
  localparam logic [15:0] NG_PCT_HIGH = 16'h0008;
  localparam logic [15:0] PCT_SCALE   = 16'h0064;
  localparam logic [15:0] SUPPLY_FULL = 16'h00FF;

  // ********************************
  // Calibration arithmetic
  // ********************************
  localparam logic [7:0] COMP_BASE  = 8'h0D;
  localparam int         COMP_SHIFT = 3;
  localparam int         AMP_SHIFT  = 6;

  typedef enum logic [1:0] {
    PHASE_SUSTAIN,
    PHASE_OVERDRIVE,
    PHASE_BRAKE
  } drive_phase_e;

  typedef struct packed {
    logic         closed_loop;
    drive_phase_e phase;
    logic [7:0]   magnitude;
  } drive_req_s;

endpackage

// ==== design/cl_gate_limit.sv ====
// Output level shaping: full-scale scaling, overdrive limit and noise gate.
// Assumes register values stable from the parent; purely combinational.
`timescale 1ns/1ps
module cl_gate_limit (
  input  wire cl_drive_pkg::drive_req_s i_req,
  input  wire logic [7:0]               i_fullscale,
  input  wire logic [7:0]               i_od_limit,
  input  wire logic                     i_ng_high,
  output logic [7:0]                    o_level,
  output logic                          o_gated
);

  logic [15:0] scaled;
  logic [7:0]  shaped;
  logic [15:0] pct;

  always_comb begin
    scaled = (16'(i_req.magnitude) * 16'(i_fullscale)) / cl_drive_pkg::SUPPLY_FULL;
    shaped = i_req.magnitude;
    if (i_req.closed_loop) begin
      if (i_req.phase == cl_drive_pkg::PHASE_SUSTAIN) begin
        shaped = scaled[7:0];
      end else if (i_req.magnitude > i_od_limit) begin
        shaped = i_od_limit;
      end
    end
    pct = i_ng_high ? cl_drive_pkg::NG_PCT_HIGH : cl_drive_pkg::NG_PCT_LOW;
    o_gated = (16'(shaped) * cl_drive_pkg::PCT_SCALE) < (pct * cl_drive_pkg::SUPPLY_FULL);
    o_level = o_gated ? 8'h00 : shaped;
  end

endmodule

// ==== design/cl_brake_gain.sv ====
// Feedback gain selection for driving and braking.
// Assumes the calibrated gain and ratio code come from registers.
`timescale 1ns/1ps
module cl_brake_gain (
  input  wire logic [7:0]  i_gain_result,
  input  wire logic [2:0]  i_ratio_code,
  input  wire logic        i_braking,
  output logic [12:0]      o_gain
);

  logic [4:0] ratio;

  always_comb begin
    case (i_ratio_code)
      3'h0:    ratio = 5'h01;
      3'h1:    ratio = 5'h02;
      3'h2:    ratio = 5'h03;
      3'h3:    ratio = 5'h04;
      3'h4:    ratio = 5'h06;
      3'h5:    ratio = 5'h08;
      3'h6:    ratio = 5'h10;
      default: ratio = 5'h00;
    endcase
    if (i_braking) begin
      o_gain = 13'(i_gain_result) * 13'(ratio);
    end else begin
      o_gain = 13'(i_gain_result);
    end
  end

endmodule

// ==== design/closed_loop_drive_config_regs.sv ====
// Configuration and calibration-result registers of the closed-loop driver.
// Assumes a same-clock host port, playback request and impedance measurement.
//
// Contract
// - In closed loop, full-scale reference register (reset 63) scales sustain output.
// - Calibration reads the full-scale reference as an input.
// - In closed loop, overdrive and braking output is limited to the overdrive limit register.
// - Calibration stores its compensation result, reset 13, in the compensation register.
// - Compensation result is derived from the measured actuator impedance.
// - Feedback gain is derived from the calibrated gain register, reset 109.
// - Drive below noise gate level outputs zero; 4% clear, 8% set.
// - Bits 6 to 4, reset 3, pick braking to driving gain ratio.
// - Ratio codes 0..6 give 1,2,3,4,6,8,16; code 7 disables braking.
// - Loop gain bits 3 to 2 set settling speed, very slow to very fast.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module closed_loop_drive_config_regs (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_reset,
  input  wire logic [7:0]               i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic [7:0]                    o_rdata,
  input  wire cl_drive_pkg::drive_req_s i_req,
  input  wire logic                     i_cal_start,
  input  wire logic                     i_imp_valid,
  input  wire logic [7:0]               i_imp_code,
  output logic [7:0]                    o_drive,
  output logic                          o_drive_gated,
  output logic [12:0]                   o_feedback_gain,
  output logic [1:0]                    o_loop_gain,
  output logic [1:0]                    o_backemf_amp_gain,
  output logic                          o_cal_busy,
  output logic                          o_cal_done
);

  // ********************************
  // Registers
  // ********************************
  logic [7:0] fullscale_q;
  logic [7:0] overdrive_limit_q;
  logic [7:0] comp_q;
  logic [7:0] feedback_gain_result_q;
  logic [7:0] fb_ctrl_q;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_MEASURE,
    CAL_STORE
  } cal_state_e;

  cal_state_e cal_state_q;
  logic [7:0] cal_ref_q;
  logic [7:0] cal_imp_q;
  logic [7:0] cal_comp_d;
  logic [8:0] cal_gain_sum;
  logic [7:0] cal_gain_d;
  logic [1:0] cal_amp_d;
  logic       cal_store;
  logic       noise_gate_level;
  logic [2:0] brake_gain_ratio;
  logic [7:0] level;
  logic       gated;
  logic [12:0] gain;

  assign noise_gate_level = fb_ctrl_q[cl_drive_pkg::NG_BIT];
  assign brake_gain_ratio = fb_ctrl_q[cl_drive_pkg::BRAKE_MSB:cl_drive_pkg::BRAKE_LSB];
  assign cal_store        = (cal_state_q == CAL_STORE);

  // ********************************
  // Calibration results
  // ********************************
  always_comb begin
    cal_comp_d   = cl_drive_pkg::COMP_BASE + (cal_imp_q >> cl_drive_pkg::COMP_SHIFT);
    cal_gain_sum = 9'(cal_ref_q) + 9'(cal_ref_q >> 1);
    cal_gain_d   = cal_gain_sum[8] ? 8'hFF : cal_gain_sum[7:0];
    cal_amp_d    = 2'(cal_imp_q >> cl_drive_pkg::AMP_SHIFT);
  end

  // ********************************
  // Register writes
  // ********************************
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      fullscale_q       <= cl_drive_pkg::RST_FULLSCALE;
      overdrive_limit_q <= cl_drive_pkg::RST_OD_LIMIT;
    end else if (i_wr) begin
      if (i_addr == cl_drive_pkg::ADDR_FULLSCALE) begin
        fullscale_q <= i_wdata;
      end
      if (i_addr == cl_drive_pkg::ADDR_OD_LIMIT) begin
        overdrive_limit_q <= i_wdata;
      end
    end
  end

  // Calibration store wins over a host write in the same cycle
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      comp_q                 <= cl_drive_pkg::RST_COMP;
      feedback_gain_result_q <= cl_drive_pkg::RST_FB_GAIN;
      fb_ctrl_q              <= cl_drive_pkg::RST_FB_CTRL;
    end else if (cal_store) begin
      comp_q                 <= cal_comp_d;
      feedback_gain_result_q <= cal_gain_d;
      fb_ctrl_q[cl_drive_pkg::AMP_MSB:cl_drive_pkg::AMP_LSB] <= cal_amp_d;
    end else if (i_wr) begin
      if (i_addr == cl_drive_pkg::ADDR_COMP) begin
        comp_q <= i_wdata;
      end
      if (i_addr == cl_drive_pkg::ADDR_FB_GAIN) begin
        feedback_gain_result_q <= i_wdata;
      end
      if (i_addr == cl_drive_pkg::ADDR_FB_CTRL) begin
        fb_ctrl_q <= i_wdata;
      end
    end
  end

  // ********************************
  // Register reads
  // ********************************
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        cl_drive_pkg::ADDR_FULLSCALE: o_rdata <= fullscale_q;
        cl_drive_pkg::ADDR_OD_LIMIT:  o_rdata <= overdrive_limit_q;
        cl_drive_pkg::ADDR_COMP:      o_rdata <= comp_q;
        cl_drive_pkg::ADDR_FB_GAIN:   o_rdata <= feedback_gain_result_q;
        cl_drive_pkg::ADDR_FB_CTRL:   o_rdata <= fb_ctrl_q;
        default:                      o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ********************************
  // Calibration sequencer
  // ********************************
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cal_state_q <= CAL_IDLE;
      cal_ref_q   <= 8'h00;
      cal_imp_q   <= 8'h00;
    end else begin
      case (cal_state_q)
        CAL_IDLE: begin
          if (i_cal_start) begin
            cal_ref_q   <= fullscale_q;
            cal_state_q <= CAL_MEASURE;
          end
        end
        CAL_MEASURE: begin
          if (i_imp_valid) begin
            cal_imp_q   <= i_imp_code;
            cal_state_q <= CAL_STORE;
          end
        end
        CAL_STORE: begin
          cal_state_q <= CAL_IDLE;
        end
        default: begin
          cal_state_q <= CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cal_busy <= 1'b0;
      o_cal_done <= 1'b0;
    end else begin
      o_cal_busy <= (cal_state_q != CAL_IDLE) || i_cal_start;
      o_cal_done <= cal_store;
    end
  end

  // ********************************
  // Drive path
  // ********************************
  cl_gate_limit u_gate_limit (
    .i_req       (i_req),
    .i_fullscale (fullscale_q),
    .i_od_limit  (overdrive_limit_q),
    .i_ng_high   (noise_gate_level),
    .o_level     (level),
    .o_gated     (gated)
  );

  cl_brake_gain u_brake_gain (
    .i_gain_result (feedback_gain_result_q),
    .i_ratio_code  (brake_gain_ratio),
    .i_braking     (i_req.closed_loop && i_req.phase == cl_drive_pkg::PHASE_BRAKE),
    .o_gain        (gain)
  );

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_drive       <= 8'h00;
      o_drive_gated <= 1'b1;
    end else begin
      o_drive       <= level;
      o_drive_gated <= gated;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_feedback_gain    <= 13'h0000;
      o_loop_gain        <= 2'h0;
      o_backemf_amp_gain <= 2'h0;
    end else begin
      o_feedback_gain    <= gain;
      o_loop_gain        <= fb_ctrl_q[cl_drive_pkg::LOOP_MSB:cl_drive_pkg::LOOP_LSB];
      o_backemf_amp_gain <= fb_ctrl_q[cl_drive_pkg::AMP_MSB:cl_drive_pkg::AMP_LSB];
    end
  end

  // ********************************
  // Checks
  // ********************************
  logic first_q;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  reset_defaults_a: assert property (
    first_q |-> (fullscale_q == 8'h3F && comp_q == 8'h0D
                 && feedback_gain_result_q == 8'h6D && fb_ctrl_q == 8'h36
                 && overdrive_limit_q == 8'hFF))
    else $error("register defaults wrong after reset");

  sustain_ref_a: assert property (
    (i_req.closed_loop && i_req.phase == cl_drive_pkg::PHASE_SUSTAIN)
    |=> o_drive <= $past(fullscale_q))
    else $error("sustain drive above full-scale reference");

  od_limit_a: assert property (
    (i_req.closed_loop && i_req.phase != cl_drive_pkg::PHASE_SUSTAIN)
    |=> o_drive <= $past(overdrive_limit_q))
    else $error("overdrive or brake drive above limit");

  noise_gate_a: assert property (
    (i_req.closed_loop == 1'b0 && i_req.magnitude <= 8'h0A)
    |=> (o_drive == 8'h00 && o_drive_gated))
    else $error("small drive not gated to zero");

  sequence cal_launch_s;
    (cal_state_q == CAL_IDLE && i_cal_start) ##1 (cal_state_q == CAL_MEASURE);
  endsequence

  sequence cal_measure_s;
    (cal_state_q == CAL_MEASURE && i_imp_valid) ##1 cal_store;
  endsequence

  cal_comp_a: assert property (
    (cal_state_q == CAL_MEASURE && i_imp_valid) |-> ##2
      (comp_q == 8'h0D + ($past(i_imp_code, 2) >> 3) && o_cal_done))
    else $error("compensation result not stored");

  cal_ref_a: assert property (
    cal_launch_s |-> (cal_ref_q == $past(fullscale_q)))
    else $error("calibration did not sample reference at launch");

  cal_flow_a: assert property (
    cal_measure_s |=> (cal_state_q == CAL_IDLE && o_cal_done && !cal_store))
    else $error("calibration did not finish after measurement");

  brake_off_a: assert property (
    (i_req.closed_loop && i_req.phase == cl_drive_pkg::PHASE_BRAKE
     && brake_gain_ratio == cl_drive_pkg::BRAKE_OFF_CODE) |=> o_feedback_gain == 13'h0000)
    else $error("braking gain not removed for code 7");

  brake_ratio_a: assert property (
    (i_req.closed_loop && i_req.phase == cl_drive_pkg::PHASE_BRAKE
     && brake_gain_ratio == 3'h6) |=> o_feedback_gain == 13'($past(feedback_gain_result_q)) * 13'h10)
    else $error("braking gain ratio 16 wrong");

  drive_gain_a: assert property (
    (i_req.phase == cl_drive_pkg::PHASE_SUSTAIN)
    |=> o_feedback_gain == 13'($past(feedback_gain_result_q)))
    else $error("driving gain differs from calibrated gain");

  loop_gain_a: assert property (
    (i_wr && i_addr == 8'h23 && !cal_store) |=> ##1 o_loop_gain == $past(i_wdata[3:2], 2))
    else $error("loop gain not taken from control register");

  cal_gain_a: assert property (
    (cal_state_q == CAL_MEASURE && i_imp_valid) |-> ##2
      (feedback_gain_result_q == 8'hFF
       || 9'(feedback_gain_result_q) == 9'(cal_ref_q) + 9'(cal_ref_q >> 1)))
    else $error("feedback gain result not derived from reference");

  cal_amp_a: assert property (
    (cal_state_q == CAL_MEASURE && i_imp_valid) |-> ##2
      (fb_ctrl_q[cl_drive_pkg::AMP_MSB:cl_drive_pkg::AMP_LSB] == $past(i_imp_code[7:6], 2)))
    else $error("amplifier gain not taken from impedance");

  store_wins_a: assert property (
    (cal_store && i_wr && i_addr == cl_drive_pkg::ADDR_COMP) |=> comp_q == $past(cal_comp_d))
    else $error("host write overrode calibration result");

  host_write_a: assert property (
    (i_wr && i_addr == cl_drive_pkg::ADDR_FULLSCALE) |=> fullscale_q == $past(i_wdata))
    else $error("full-scale reference write lost");

  overdrive_limit_hit_a: assert property (
    (i_req.closed_loop && i_req.phase != cl_drive_pkg::PHASE_SUSTAIN
     && i_req.magnitude > overdrive_limit_q)
    |=> (o_drive == $past(overdrive_limit_q) || o_drive_gated))
    else $error("overdrive drive not clamped to limit");

  gate_high_a: assert property (
    (!i_req.closed_loop && noise_gate_level && i_req.magnitude <= 8'h14) |=> o_drive_gated)
    else $error("drive below upper noise gate level passed");

  gate_open_a: assert property (
    (!i_req.closed_loop && !noise_gate_level && i_req.magnitude >= 8'h0B)
    |=> (o_drive_gated == 1'b0 && o_drive == $past(i_req.magnitude)))
    else $error("drive above lower noise gate level blocked");

  open_gain_a: assert property (
    !i_req.closed_loop |=> o_feedback_gain == 13'($past(feedback_gain_result_q)))
    else $error("open loop gain differs from calibrated gain");

  read_idle_a: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data held beyond one cycle");

endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the closed-loop drive configuration registers.
// Assumes the design package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module tb_top;
  // ********************************
  // Signals and model state
  // ********************************
  logic                     i_sys_clk;
  logic                     i_reset;
  logic [7:0]               i_addr;
  logic [7:0]               i_wdata;
  logic                     i_wr;
  logic                     i_rd;
  logic [7:0]               o_rdata;
  cl_drive_pkg::drive_req_s i_req;
  logic                     i_cal_start;
  logic                     i_imp_valid;
  logic [7:0]               i_imp_code;
  logic [7:0]               o_drive;
  logic                     o_drive_gated;
  logic [12:0]              o_feedback_gain;
  logic [1:0]               o_loop_gain;
  logic [1:0]               o_backemf_amp_gain;
  logic                     o_cal_busy;
  logic                     o_cal_done;
  int                       fails;
  int                       checks;
  logic [7:0]               m [5];

  closed_loop_drive_config_regs dut (
    .i_sys_clk          (i_sys_clk),
    .i_reset            (i_reset),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .o_rdata            (o_rdata),
    .i_req              (i_req),
    .i_cal_start        (i_cal_start),
    .i_imp_valid        (i_imp_valid),
    .i_imp_code         (i_imp_code),
    .o_drive            (o_drive),
    .o_drive_gated      (o_drive_gated),
    .o_feedback_gain    (o_feedback_gain),
    .o_loop_gain        (o_loop_gain),
    .o_backemf_amp_gain (o_backemf_amp_gain),
    .o_cal_busy         (o_cal_busy),
    .o_cal_done         (o_cal_done)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // ********************************
  // Shared tasks
  // ********************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (7) @(posedge i_sys_clk);
    #1 check("gated_in_reset", o_drive_gated, 16'h0001);
    check("busy_in_reset", o_cal_busy, 16'h0000);
    @(posedge i_sys_clk);
    i_reset <= 1'b0;
    m[0] = 8'h3F;
    m[1] = 8'hFF;
    m[2] = 8'h0D;
    m[3] = 8'h6D;
    m[4] = 8'h36;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    if (a >= 8'h1F && a <= 8'h23) m[a - 8'h1F] = d;
  endtask

  task automatic rd_check(input logic [7:0] a);
    logic [7:0] e;
    e = (a >= 8'h1F && a <= 8'h23) ? m[a - 8'h1F] : 8'h00;
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 check("rdata", o_rdata, e);
    @(posedge i_sys_clk);
    #1 check("rdata_idle", o_rdata, 16'h0000);
    check("loop_gain", o_loop_gain, m[4][3:2]);
    check("amp_gain", o_backemf_amp_gain, m[4][1:0]);
  endtask

  task automatic rd_all();
    for (int a = 8'h1E; a <= 8'h24; a++) begin
      rd_check(8'(a));
    end
  endtask

  task automatic drive(input logic cl, input cl_drive_pkg::drive_phase_e ph,
                       input logic [7:0] mag);
    int lvl;
    int gain;
    int pct;
    int ratio [8];
    logic gated;
    ratio = '{1, 2, 3, 4, 6, 8, 16, 0};
    lvl = int'(mag);
    if (cl && ph == cl_drive_pkg::PHASE_SUSTAIN) lvl = int'(mag) * int'(m[0]) / 255;
    else if (cl) lvl = (mag > m[1]) ? int'(m[1]) : int'(mag);
    pct = m[4][7] ? 8 : 4;
    gated = (lvl * 100) < (pct * 255);
    gain = int'(m[3]);
    if (cl && ph == cl_drive_pkg::PHASE_BRAKE) gain = int'(m[3]) * ratio[m[4][6:4]];
    @(posedge i_sys_clk);
    i_req <= '{closed_loop: cl, phase: ph, magnitude: mag};
    @(posedge i_sys_clk);
    #1 check("drive", o_drive, gated ? 16'h0000 : 16'(lvl));
    check("gated", o_drive_gated, 16'(gated));
    check("fb_gain", o_feedback_gain, 16'(gain));
  endtask

  task automatic calibrate(input logic [7:0] imp);
    int g;
    @(posedge i_sys_clk);
    i_cal_start <= 1'b1;
    @(posedge i_sys_clk);
    i_cal_start <= 1'b0;
    #1 check("cal_busy", o_cal_busy, 16'h0001);
    repeat (2) @(posedge i_sys_clk);
    i_cal_start <= 1'b1;
    @(posedge i_sys_clk);
    i_cal_start <= 1'b0;
    i_imp_valid <= 1'b1;
    i_imp_code  <= imp;
    @(posedge i_sys_clk);
    i_imp_valid <= 1'b0;
    i_imp_code  <= ~imp;
    // Host write in the store cycle must be lost
    i_wr        <= 1'b1;
    i_addr      <= 8'h21;
    i_wdata     <= 8'hAA;
    #1 check("cal_done_early", o_cal_done, 16'h0000);
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1 check("cal_done", o_cal_done, 16'h0001);
    check("cal_busy_done", o_cal_busy, 16'h0001);
    @(posedge i_sys_clk);
    #1 check("cal_done_pulse", o_cal_done, 16'h0000);
    check("cal_idle", o_cal_busy, 16'h0000);
    g = int'(m[0]) + int'(m[0] >> 1);
    m[2] = 8'h0D + (imp >> 3);
    m[3] = (g > 255) ? 8'hFF : 8'(g);
    m[4][1:0] = imp[7:6];
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    i_reset     = 1'b1;
    i_addr      = 8'h00;
    i_wdata     = 8'h00;
    i_wr        = 1'b0;
    i_rd        = 1'b0;
    i_req       = '0;
    i_cal_start = 1'b0;
    i_imp_valid = 1'b0;
    i_imp_code  = 8'h00;
    fails       = 0;
    checks      = 0;
    void'($urandom(3252));
    do_reset();
    rd_all();
    for (int i = 0; i < 6; i++) begin
      wr(8'(8'h1F + i), 8'($urandom));
    end
    rd_all();
    wr(8'h1F, 8'($urandom));
    wr(8'h20, 8'h80);
    for (int c = 0; c < 8; c++) begin
      logic [2:0] code;
      code = c[2:0];
      wr(8'h23, {code[0], code, 4'($urandom)});
      rd_check(8'h23);
      drive(1'b1, cl_drive_pkg::PHASE_BRAKE, 8'($urandom));
      drive(1'b1, cl_drive_pkg::PHASE_OVERDRIVE, 8'($urandom));
      drive(1'b1, cl_drive_pkg::PHASE_SUSTAIN, 8'($urandom));
      drive(1'b0, cl_drive_pkg::PHASE_SUSTAIN, code[0] ? 8'h14 : 8'h0A);
      drive(1'b0, cl_drive_pkg::PHASE_BRAKE, code[0] ? 8'h15 : 8'h0B);
    end
    wr(8'h23, 8'h40);
    wr(8'h1F, 8'hB4);
    calibrate(8'($urandom));
    rd_all();
    wr(8'h1F, 8'h50);
    calibrate(8'($urandom));
    rd_all();
    drive(1'b1, cl_drive_pkg::PHASE_BRAKE, 8'hFF);
    drive(1'b1, cl_drive_pkg::PHASE_SUSTAIN, 8'hFF);
    do_reset();
    rd_all();
    drive(1'b1, cl_drive_pkg::PHASE_BRAKE, 8'h40);
    complete_run();
  end
endmodule
